// File: src/aux_cfg_pkg.sv
// Register map, field positions, reset values and codes for the aux clock block
package aux_cfg_pkg;
	// Register offsets on the serial port
	localparam logic [5:0] ADDR_AUX1 = 6'h18;
	localparam logic [5:0] ADDR_AUX2 = 6'h19;
	localparam logic [5:0] ADDR_LOCK = 6'h1a;
	localparam logic [5:0] ADDR_PINS = 6'h1b;
	localparam logic [5:0] ADDR_STATUS = 6'h1f;
	// Reset values
	localparam logic [23:0] RST_AUX1 = 24'h0000a0;
	localparam logic [23:0] RST_AUX2 = 24'h00000f;
	localparam logic [23:0] RST_LOCK = 24'h001040;
	localparam logic [23:0] RST_PINS = 24'h000000;
	// Writable bits; the rest read as zero
	localparam logic [23:0] MASK_AUX1 = 24'h7fffff;
	localparam logic [23:0] MASK_AUX2 = 24'h00001f;
	localparam logic [23:0] MASK_LOCK = 24'h0fffff;
	localparam logic [23:0] MASK_PINS = 24'h0007ff;
	// Aux register 1 fields
	localparam int AUX_SRC_LSB = 0;
	localparam int AUX_MODE_LSB = 2;
	localparam int AUX_DIV_LSB = 4;
	localparam int AUX_MODREF_BIT = 7;
	localparam int AUX_LFSR_EN_BIT = 8;
	localparam int AUX_ACC_EN_BIT = 9;
	localparam int AUX_DMOD_LSB = 10;
	localparam int AUX_STEP_LSB = 12;
	localparam int AUX_LODLY_LSB = 20;
	// Aux register 2 fields
	localparam int AUX_HIDLY_LSB = 0;
	localparam int AUX_CLKINV_BIT = 3;
	localparam int AUX_RINGCLK_BIT = 4;
	// Lock detect fields
	localparam int LOCK_THR_LSB = 0;
	localparam int LOCK_ASYM_BIT = 10;
	localparam int LOCK_AUTO_BIT = 12;
	localparam int LOCK_FORCED_BIT = 13;
	localparam int LOCK_ONESHOT_BIT = 14;
	localparam int LOCK_TEST_BIT = 19;
	// Output pin control fields
	localparam int PIN_SEL_LSB = 0;
	localparam int PIN_DATA_LSB = 4;
	localparam int PIN_DRIVE_BIT = 7;
	localparam int PIN_DIS_LSB = 8;
	// Status fields
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_BUSY_BIT = 5;
	// Aux path modes
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] MODE_DELAY = 2'h1;
	localparam logic [1:0] MODE_RING = 2'h2;
	localparam logic [1:0] MODE_GATED = 2'h3;
	// Delay modulation modes
	localparam logic [1:0] DMOD_PASS = 2'h0;
	localparam logic [1:0] DMOD_SQUARE = 2'h1;
	localparam logic [1:0] DMOD_LFSR_LO = 2'h2;
	localparam logic [1:0] DMOD_LFSR_HI = 2'h3;
	// Output select codes
	localparam logic [3:0] SEL_STATIC = 4'h0;
	localparam logic [3:0] SEL_CLOCKS = 4'h1;
	localparam logic [3:0] SEL_DETECTOR = 4'h2;
	localparam logic [3:0] SEL_SLIP = 4'h3;
	localparam logic [3:0] SEL_XREF = 4'h4;
	localparam logic [3:0] SEL_PHASE = 4'h6;
	localparam logic [3:0] SEL_AUX = 4'h7;
	localparam logic [3:0] SEL_SWEEP = 4'h8;
	// Synchronised input indices
	localparam int NUM_EXT = 19;
	localparam int IX_VCO = 0;
	localparam int IX_XREF = 1;
	localparam int IX_REF = 2;
	localparam int IX_RING = 3;
	localparam int IX_SINE = 4;
	localparam int IX_UP = 5;
	localparam int IX_DN = 6;
	localparam int IX_WIN = 7;
	localparam int IX_SATR = 8;
	localparam int IX_SATD = 9;
	localparam int IX_SLIP = 10;
	localparam int IX_FRAC = 11;
	localparam int IX_PH1 = 12;
	localparam int IX_RTEST = 15;
	localparam int IX_MCLK = 16;
	localparam int IX_BUSY = 17;
	localparam int IX_INWIN = 18;
	// LFSR seed after reset
	localparam logic [9:0] LFSR_SEED = 10'h001;
endpackage : aux_cfg_pkg

// File: src/delay_modulator.sv
// Delay modulator: 10-bit LFSR and 8-bit accumulator square wave
`timescale 1ns/10ps
module delay_modulator import aux_cfg_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic aux_rise,
	input wire logic aux_fall,
	input wire logic ring_rise,
	input wire logic lfsr_en,
	input wire logic accum_en,
	input wire logic clk_inv,
	input wire logic ring_sel,
	input wire logic [1:0] mode,
	input wire logic [7:0] step,
	input wire logic [2:0] lo_dly,
	input wire logic [2:0] hi_dly,
	output logic [2:0] delay_value
);
	typedef struct packed {
		logic [9:0] lfsr;
		logic [7:0] acc;
		logic square;
		logic [2:0] dly;
	} dmod_state_t;

	dmod_state_t r_reg;
	dmod_state_t r_next;
	logic aux_tick;
	logic lfsr_tick;
	logic [8:0] sum;

	// Tick selection on aux edge or ring edge
	assign aux_tick = clk_inv ? aux_fall : aux_rise;
	assign lfsr_tick = ring_sel ? ring_rise : aux_tick;
	assign sum = {1'b0, r_reg.acc} + {1'b0, step};

	// Next state of LFSR, accumulator and delay value
	always_comb begin
		r_next = r_reg;
		if (lfsr_en && lfsr_tick) begin
			r_next.lfsr = {r_reg.lfsr[8:0], r_reg.lfsr[9] ^ r_reg.lfsr[6]};
		end
		if (accum_en && aux_tick) begin
			r_next.acc = sum[7:0];
			if (sum[8]) begin
				r_next.square = ~r_reg.square;
			end
		end
		unique case (mode)
			DMOD_PASS: r_next.dly = lo_dly;
			DMOD_SQUARE: r_next.dly = r_reg.square ? hi_dly : lo_dly;
			DMOD_LFSR_LO: r_next.dly = {1'b0, r_reg.lfsr[1:0]};
			DMOD_LFSR_HI: r_next.dly = r_reg.lfsr[2:0];
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '{lfsr: LFSR_SEED, acc: 8'h00, square: 1'b0, dly: 3'h0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign delay_value = r_reg.dly;

	a_pass_delay: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == DMOD_PASS) |=> (delay_value == $past(lo_dly)))
		else $error("pass mode delay differs from low delay");

	a_square_toggle: assert property (@(posedge clk) disable iff (!rst_n)
		(accum_en && aux_tick && sum[8]) |=> (r_reg.square != $past(r_reg.square)))
		else $error("square wave did not toggle on wrap");
endmodule : delay_modulator

// File: src/aux_clock_lock_detect_output_mux.sv
// Aux clock generator, lock detect and output pin multiplexer
// Functional notes
// - Source select picks VCO, xref, ref or ring
// - Mode selects bypass, delay, ring, gated ring
// - Divider code 0 is 1, else 2*code
// - Modulator reference uses aux clock when set
// - Enable bits for LFSR and accumulator
// - Modulation mode chooses pass, square, LFSR amplitudes
// - Accumulator adds step; wrap toggles square
// - Low delay used in pass and square
// - High delay gives square-wave high level
// - Inversion bit clocks modulator on falling edge
// - Ring select clocks the LFSR instead
// - Lock after threshold in-window reference cycles
// - Asymmetric window and polarity bits exported
// - Auto routing puts lock on idle read pin
// - Forced routing puts lock always, blocks reads
// - One-shot select, ring speed, duration exported
// - Ring test bit runs ring oscillator alone
// - Select 0 static data, 1 clocks
// - Select 2 detector, 3 saturation and slip
// - Select 6 phase, 7 clocks, 8 sweep
// - Pins driven only with drive enable
// - Sweep busy flag shown as given
`timescale 1ns/10ps
module aux_clock_lock_detect_output_mux import aux_cfg_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [5:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	input wire logic serial_read_active,
	input wire logic serial_read_bit,
	output logic read_pin_out,
	input wire logic vco_div_clk_in,
	input wire logic xref_clk_in,
	input wire logic ref_clk_in,
	input wire logic ring_osc_in,
	input wire logic xref_sine_in,
	input wire logic detector_up_pulse,
	input wire logic detector_down_pulse,
	input wire logic lock_window_pulse,
	input wire logic sat_ref_in,
	input wire logic sat_div_in,
	input wire logic cycle_slip_strobe,
	input wire logic synced_fraction_update_strobe,
	input wire logic [2:0] quantized_phase_bits,
	input wire logic ring_test_clk,
	input wire logic modulator_clock,
	input wire logic sweep_busy,
	input wire logic phase_in_window,
	output logic aux_clk_out,
	output logic modulator_ref_clk,
	output logic [2:0] delay_value,
	output logic [7:0] lock_window_ctrl,
	output logic lock_detect,
	output logic output_pin_one_out,
	output logic output_pin_one_oe,
	output logic output_pin_two_out,
	output logic output_pin_two_oe,
	output logic output_pin_three_out,
	output logic output_pin_three_oe
);
	typedef struct packed {
		logic [23:0] cfg_aux1;
		logic [23:0] cfg_aux2;
		logic [23:0] cfg_lock;
		logic [23:0] cfg_pins;
		logic [NUM_EXT-1:0] s1;
		logic [NUM_EXT-1:0] s2;
		logic [NUM_EXT-1:0] s3;
		logic [NUM_EXT-1:0] filt;
		logic [NUM_EXT-1:0] filt_q;
		logic [2:0] div_cnt;
		logic div_clk;
		logic [7:0] dly_line;
		logic aux_clk;
		logic aux_q;
		logic mod_ref;
		logic [9:0] lock_cnt;
		logic locked;
		logic [2:0] pin_val;
		logic read_pin;
		logic [23:0] rdata;
	} top_state_t;

	localparam top_state_t RST_STATE = '{
		cfg_aux1: RST_AUX1, cfg_aux2: RST_AUX2, cfg_lock: RST_LOCK, cfg_pins: RST_PINS,
		s1: '0, s2: '0, s3: '0, filt: '0, filt_q: '0, div_cnt: 3'h0, div_clk: 1'b0,
		dly_line: 8'h00, aux_clk: 1'b0, aux_q: 1'b0, mod_ref: 1'b0, lock_cnt: 10'h000,
		locked: 1'b0, pin_val: 3'h0, read_pin: 1'b0, rdata: 24'h000000};

	logic [1:0] rst_sync_reg;
	logic rst_n;
	top_state_t r_reg;
	top_state_t r_next;
	logic [NUM_EXT-1:0] ext_in;
	logic [NUM_EXT-1:0] agreed;
	logic [1:0] src_sel;
	logic [1:0] aux_mode;
	logic [2:0] div_sel;
	logic [2:0] mod_dly;
	logic [3:0] pin_sel;
	logic [9:0] lock_thr;
	logic src_now;
	logic src_rise;
	logic ref_rise;
	logic ring_rise;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Foreign inputs gathered for synchronisation
	assign ext_in = {phase_in_window, sweep_busy, modulator_clock, ring_test_clk,
		quantized_phase_bits, synced_fraction_update_strobe, cycle_slip_strobe,
		sat_div_in, sat_ref_in, lock_window_pulse, detector_down_pulse,
		detector_up_pulse, xref_sine_in, ring_osc_in, ref_clk_in, xref_clk_in,
		vco_div_clk_in};

	// Change accepted once second and third stages agree
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_agree
			assign agreed[gi] = (r_reg.s2[gi] == r_reg.s3[gi]) ? r_reg.s2[gi] : r_reg.filt[gi];
		end
	endgenerate

	// Field decode
	assign src_sel = r_reg.cfg_aux1[AUX_SRC_LSB +: 2];
	assign aux_mode = r_reg.cfg_aux1[AUX_MODE_LSB +: 2];
	assign div_sel = r_reg.cfg_aux1[AUX_DIV_LSB +: 3];
	assign pin_sel = r_reg.cfg_pins[PIN_SEL_LSB +: 4];
	assign lock_thr = r_reg.cfg_lock[LOCK_THR_LSB +: 10];
	assign src_now = r_reg.filt[src_sel];
	assign src_rise = src_now & ~r_reg.filt_q[src_sel];
	assign ref_rise = r_reg.filt[IX_REF] & ~r_reg.filt_q[IX_REF];
	assign ring_rise = r_reg.filt[IX_RING] & ~r_reg.filt_q[IX_RING];

	// Next state of the whole block
	always_comb begin
		r_next = r_reg;
		r_next.s1 = ext_in;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = agreed;
		r_next.filt_q = r_reg.filt;
		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_AUX1: r_next.cfg_aux1 = reg_wdata & MASK_AUX1;
				ADDR_AUX2: r_next.cfg_aux2 = reg_wdata & MASK_AUX2;
				ADDR_LOCK: r_next.cfg_lock = reg_wdata & MASK_LOCK;
				ADDR_PINS: r_next.cfg_pins = reg_wdata & MASK_PINS;
				default: r_next.cfg_aux1 = r_reg.cfg_aux1;
			endcase
		end
		// Register reads
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_AUX1: r_next.rdata = r_reg.cfg_aux1;
				ADDR_AUX2: r_next.rdata = r_reg.cfg_aux2;
				ADDR_LOCK: r_next.rdata = r_reg.cfg_lock;
				ADDR_PINS: r_next.rdata = r_reg.cfg_pins;
				ADDR_STATUS: begin
					r_next.rdata = 24'h000000;
					r_next.rdata[STAT_LOCK_BIT] = r_reg.locked;
					r_next.rdata[STAT_BUSY_BIT] = r_reg.filt[IX_BUSY];
				end
				default: r_next.rdata = 24'h000000;
			endcase
		end
		// Even divider, half period of div_sel source edges
		if (div_sel == 3'h0) begin
			r_next.div_clk = src_now;
			r_next.div_cnt = 3'h0;
		end else if (src_rise) begin
			if (r_reg.div_cnt >= div_sel - 3'h1) begin
				r_next.div_clk = ~r_reg.div_clk;
				r_next.div_cnt = 3'h0;
			end else begin
				r_next.div_cnt = r_reg.div_cnt + 3'h1;
			end
		end
		r_next.dly_line = {r_reg.dly_line[6:0], r_reg.div_clk};
		// Aux path mode
		unique case (aux_mode)
			MODE_BYPASS: r_next.aux_clk = r_reg.div_clk;
			MODE_DELAY: r_next.aux_clk = r_reg.dly_line[mod_dly];
			MODE_RING: r_next.aux_clk = r_reg.filt[IX_RING];
			MODE_GATED: r_next.aux_clk = r_reg.filt[IX_RING] & r_reg.div_clk;
		endcase
		r_next.aux_q = r_reg.aux_clk;
		// Modulator reference choice
		r_next.mod_ref = r_reg.cfg_aux1[AUX_MODREF_BIT] ? r_reg.aux_clk
			: r_reg.filt[IX_REF];
		// Lock counter on reference edges
		if (ref_rise) begin
			if (r_reg.filt[IX_INWIN]) begin
				if (r_reg.lock_cnt < lock_thr) begin
					r_next.lock_cnt = r_reg.lock_cnt + 10'h001;
				end
				r_next.locked = ({1'b0, r_reg.lock_cnt} + 11'h001 >= {1'b0, lock_thr});
			end else begin
				r_next.lock_cnt = 10'h000;
				r_next.locked = 1'b0;
			end
		end
		// Serial read pin routing
		if (r_reg.cfg_lock[LOCK_FORCED_BIT]) begin
			r_next.read_pin = r_reg.locked;
		end else if (serial_read_active) begin
			r_next.read_pin = serial_read_bit;
		end else begin
			r_next.read_pin = r_reg.cfg_lock[LOCK_AUTO_BIT] & r_reg.locked;
		end
		// Output pin multiplexer, index 2 is pin three
		unique case (pin_sel)
			SEL_STATIC: r_next.pin_val = r_reg.cfg_pins[PIN_DATA_LSB +: 3];
			SEL_CLOCKS: r_next.pin_val = {r_reg.filt[IX_XREF], r_reg.filt[IX_REF],
				r_reg.filt[IX_VCO]};
			SEL_DETECTOR: r_next.pin_val = {r_reg.filt[IX_UP], r_reg.filt[IX_DN],
				r_reg.filt[IX_WIN]};
			SEL_SLIP: r_next.pin_val = {r_reg.filt[IX_SATR], r_reg.filt[IX_SATD],
				r_reg.filt[IX_SLIP]};
			SEL_XREF: r_next.pin_val = {r_reg.filt[IX_XREF], r_reg.filt[IX_SINE],
				r_reg.filt[IX_FRAC]};
			SEL_PHASE: r_next.pin_val = {r_reg.filt[IX_PH1], r_reg.filt[IX_PH1 + 1],
				r_reg.filt[IX_PH1 + 2]};
			SEL_AUX: r_next.pin_val = {r_reg.aux_clk, r_reg.filt[IX_RTEST],
				r_reg.filt[IX_MCLK]};
			SEL_SWEEP: r_next.pin_val = {1'b0, r_reg.filt[IX_BUSY], 1'b0};
			default: r_next.pin_val = 3'h0;
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= RST_STATE;
		end else begin
			r_reg <= r_next;
		end
	end

	// Delay modulator behind the aux clock
	delay_modulator u_dmod (
		.clk(clk),
		.rst_n(rst_n),
		.aux_rise(r_reg.aux_clk & ~r_reg.aux_q),
		.aux_fall(~r_reg.aux_clk & r_reg.aux_q),
		.ring_rise(ring_rise),
		.lfsr_en(r_reg.cfg_aux1[AUX_LFSR_EN_BIT]),
		.accum_en(r_reg.cfg_aux1[AUX_ACC_EN_BIT]),
		.clk_inv(r_reg.cfg_aux2[AUX_CLKINV_BIT]),
		.ring_sel(r_reg.cfg_aux2[AUX_RINGCLK_BIT]),
		.mode(r_reg.cfg_aux1[AUX_DMOD_LSB +: 2]),
		.step(r_reg.cfg_aux1[AUX_STEP_LSB +: 8]),
		.lo_dly(r_reg.cfg_aux1[AUX_LODLY_LSB +: 3]),
		.hi_dly(r_reg.cfg_aux2[AUX_HIDLY_LSB +: 3]),
		.delay_value(mod_dly)
	);

	// Outputs
	assign delay_value = mod_dly;
	assign reg_rdata = r_reg.rdata;
	assign read_pin_out = r_reg.read_pin;
	assign aux_clk_out = r_reg.aux_clk;
	assign modulator_ref_clk = r_reg.mod_ref;
	assign lock_detect = r_reg.locked;
	// Window shaping and ring test controls to the analog detector
	assign lock_window_ctrl = {r_reg.cfg_lock[LOCK_TEST_BIT:LOCK_ONESHOT_BIT],
		r_reg.cfg_lock[LOCK_ASYM_BIT +: 2]};
	assign output_pin_one_out = r_reg.pin_val[0];
	assign output_pin_two_out = r_reg.pin_val[1];
	assign output_pin_three_out = r_reg.pin_val[2];
	// Pad drivers need global enable and no individual disable
	assign output_pin_one_oe = r_reg.cfg_pins[PIN_DRIVE_BIT] & ~r_reg.cfg_pins[PIN_DIS_LSB];
	assign output_pin_two_oe = r_reg.cfg_pins[PIN_DRIVE_BIT] & ~r_reg.cfg_pins[PIN_DIS_LSB + 1];
	assign output_pin_three_oe = r_reg.cfg_pins[PIN_DRIVE_BIT] & ~r_reg.cfg_pins[PIN_DIS_LSB + 2];

	// Write of static select followed by a quiet cycle
	sequence static_sel_write;
		reg_wr && reg_addr == ADDR_PINS && reg_wdata[3:0] == SEL_STATIC ##1 !reg_wr;
	endsequence

	a_static_pins: assert property (@(posedge clk) disable iff (!rst_n)
		static_sel_write |=> ({output_pin_three_out, output_pin_two_out, output_pin_one_out}
			== $past(reg_wdata[6:4], 2)))
		else $error("static pin data not applied after select write");

	a_pins_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!r_reg.cfg_pins[PIN_DRIVE_BIT] |->
			!(output_pin_one_oe || output_pin_two_oe || output_pin_three_oe))
		else $error("pin driven without drive enable");

	a_forced_lock: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.cfg_lock[LOCK_FORCED_BIT] |=> (read_pin_out == $past(r_reg.locked)))
		else $error("forced routing did not show lock");

	a_auto_lock: assert property (@(posedge clk) disable iff (!rst_n)
		(r_reg.cfg_lock[LOCK_AUTO_BIT] && !r_reg.cfg_lock[LOCK_FORCED_BIT]
			&& !serial_read_active) |=> (read_pin_out == $past(r_reg.locked)))
		else $error("auto routing did not show lock on idle pin");

	a_lock_drop: assert property (@(posedge clk) disable iff (!rst_n)
		(ref_rise && !r_reg.filt[IX_INWIN]) |=> (!lock_detect && r_reg.lock_cnt == 10'h000))
		else $error("lock kept after out-of-window cycle");

	a_lock_cause: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(lock_detect) |-> $past(ref_rise && r_reg.filt[IX_INWIN]) && r_reg.lock_cnt >= lock_thr)
		else $error("lock declared without in-window reference edge");

	a_ring_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(aux_mode == MODE_RING) |=> (aux_clk_out == $past(r_reg.filt[IX_RING])))
		else $error("ring mode aux clock wrong");

	a_mod_ref: assert property (@(posedge clk) disable iff (!rst_n)
		r_reg.cfg_aux1[AUX_MODREF_BIT] |=> (modulator_ref_clk == $past(aux_clk_out)))
		else $error("modulator reference not aux clock");

	a_sweep_pins: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_sel == SEL_SWEEP) |=> (!output_pin_three_out && !output_pin_one_out
			&& output_pin_two_out == $past(r_reg.filt[IX_BUSY])))
		else $error("sweep select pins wrong");
endmodule : aux_clock_lock_detect_output_mux

// File: verification/gpo_pin_monitor.sv
// Far-side model of the three output pads
`timescale 1ns/10ps
module gpo_pin_monitor (
	input wire logic clk,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	output logic [2:0] pad
);
	logic [2:0] last_reg;
	// Released pads float to the inverse of the last driven level
	always_comb begin
		pad = (pin_oe & pin_out) | (~pin_oe & ~last_reg);
	end
	// Remember the last driven level per pad
	always_ff @(posedge clk) begin
		last_reg <= (pin_oe & pin_out) | (~pin_oe & last_reg);
	end
endmodule : gpo_pin_monitor

// File: verification/testbench.sv
// Register, pin multiplexer, divider, delay and lock checks for the aux clock block
`timescale 1ns/10ps
module testbench import aux_cfg_pkg::*;;
	logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [23:0] reg_wdata = 24'h000000, reg_rdata, rd_val;
	logic srd_act = 1'b0, srd_bit = 1'b0, read_pin_out, aux_clk_out, mref;
	logic [18:0] ext = 19'h00000;
	logic [2:0] dly, p_out, p_oe, pad;
	logic [7:0] seen, lwc;
	logic aux_prev = 1'b0, mref_prev = 1'b0, lock_detect;
	int miscompares = 0, comparisons = 0, aux_n = 0, mref_n = 0, ratio = 1;
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hf};
	// Clock at 40 ns period
	always #20 clk = ~clk;
	aux_clock_lock_detect_output_mux dut (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.serial_read_active(srd_act), .serial_read_bit(srd_bit), .read_pin_out(read_pin_out),
		.vco_div_clk_in(ext[IX_VCO]), .xref_clk_in(ext[IX_XREF]), .ref_clk_in(ext[IX_REF]),
		.ring_osc_in(ext[IX_RING]), .xref_sine_in(ext[IX_SINE]),
		.detector_up_pulse(ext[IX_UP]), .detector_down_pulse(ext[IX_DN]),
		.lock_window_pulse(ext[IX_WIN]), .sat_ref_in(ext[IX_SATR]), .sat_div_in(ext[IX_SATD]),
		.cycle_slip_strobe(ext[IX_SLIP]), .synced_fraction_update_strobe(ext[IX_FRAC]),
		.quantized_phase_bits(ext[IX_PH1+2:IX_PH1]), .ring_test_clk(ext[IX_RTEST]),
		.modulator_clock(ext[IX_MCLK]), .sweep_busy(ext[IX_BUSY]),
		.phase_in_window(ext[IX_INWIN]), .aux_clk_out(aux_clk_out), .modulator_ref_clk(mref),
		.delay_value(dly), .lock_window_ctrl(lwc), .lock_detect(lock_detect),
		.output_pin_one_out(p_out[0]), .output_pin_one_oe(p_oe[0]),
		.output_pin_two_out(p_out[1]), .output_pin_two_oe(p_oe[1]),
		.output_pin_three_out(p_out[2]), .output_pin_three_oe(p_oe[2]));
	gpo_pin_monitor pins (.clk(clk), .pin_out(p_out), .pin_oe(p_oe), .pad(pad));
	// Edge counters and delay values, sampled once outputs settle
	always @(posedge clk) begin
		#10;
		if (aux_clk_out === 1'b1 && aux_prev === 1'b0) aux_n++;
		if (mref === 1'b1 && mref_prev === 1'b0) mref_n++;
		aux_prev = aux_clk_out;
		mref_prev = mref;
		seen[dly] = 1'b1;
	end
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task chk(input string name, input logic [23:0] e, input logic [23:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, e, s);
		end
	endtask : chk
	task wr(input logic [5:0] a, input logic [23:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task rchk(input logic [5:0] a, input logic [23:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask : rchk
	// Toggle one foreign clock n periods of six cycles
	task pulse(input int idx, input int n);
		repeat (n) begin
			ext[idx] = 1'b1;
			cyc(3);
			ext[idx] = 1'b0;
			cyc(3);
		end
	endtask : pulse
	function automatic logic [2:0] pin_exp(input logic [3:0] c);
		case (c)
			4'h0: return 3'h5;
			4'h1: return {ext[IX_XREF], ext[IX_REF], ext[IX_VCO]};
			4'h2: return {ext[IX_UP], ext[IX_DN], ext[IX_WIN]};
			4'h3: return {ext[IX_SATR], ext[IX_SATD], ext[IX_SLIP]};
			4'h4: return {ext[IX_XREF], ext[IX_SINE], ext[IX_FRAC]};
			4'h6: return {ext[IX_PH1], ext[IX_PH1+1], ext[IX_PH1+2]};
			4'h7: return {aux_clk_out, ext[IX_RTEST], ext[IX_MCLK]};
			4'h8: return {1'b0, ext[IX_BUSY], 1'b0};
			default: return 3'h0;
		endcase
	endfunction : pin_exp
	task close_out;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out
	// Cut a hung run short
	initial begin
		#1ms;
		miscompares++;
		close_out;
	end
	// Main sequence
	initial begin
		cyc(12);
		arst_n = 1'b1;
		cyc(4);
		rchk(ADDR_AUX1, 24'h0000a0);
		rchk(ADDR_AUX2, 24'h00000f);
		rchk(ADDR_LOCK, 24'h001040);
		rchk(ADDR_PINS, 24'h000000);
		rchk(6'h00, 24'h000000);
		foreach (codes[i]) wr(ADDR_AUX1 + 6'(i / 3), 24'hffffff);
		rchk(ADDR_AUX1, 24'h7fffff);
		rchk(ADDR_AUX2, 24'h00001f);
		rchk(ADDR_LOCK, 24'h0fffff);
		rchk(ADDR_PINS, 24'h0007ff);
		wr(ADDR_LOCK, 24'h0a4c05);
		chk("window controls", 24'ha7, 24'(lwc));
		$display("test registers done");
		// Every select code with two opposite input patterns
		foreach (codes[i]) begin
			wr(ADDR_PINS, 24'h0000d0 | 24'(codes[i]));
			for (int p = 0; p < 2; p++) begin
				ext = p ? 19'h2b56a : 19'h54a95;
				cyc(8);
				chk("pin enables", 24'h7, 24'(p_oe));
				chk($sformatf("pins code %h", codes[i]),
					24'(pin_exp(codes[i])), 24'(pad));
			end
		end
		wr(ADDR_PINS, 24'h000580);
		cyc(3);
		chk("pin enables", 24'h2, 24'(p_oe));
		wr(ADDR_PINS, 24'h000000);
		cyc(3);
		chk("pin enables", 24'h0, 24'(p_oe));
		$display("test pins done");
		// Divide ratios from vco and ref sources
		ext = 19'h00000;
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_AUX1, 24'h000080 | 24'(k == 3 ? 6'h12 : {3'((1 << k) - 1), 4'h0}));
			pulse(k == 3 ? IX_REF : IX_VCO, 6);
			aux_n = 0;
			mref_n = 0;
			pulse(k == 3 ? IX_REF : IX_VCO, 42);
			// Code 0 divides by 1, any other code c by 2*c
			ratio = (k == 3) ? 2 : ((k == 0) ? 1 : 2 * ((1 << k) - 1));
			chk("aux rises", 24'h1, 24'(aux_n * ratio >= 36 && aux_n * ratio <= 48));
			chk("modulator ref rises", 24'(aux_n), 24'(mref_n));
		end
		// Ring mode follows the ring oscillator one for one
		wr(ADDR_AUX1, 24'h0000a8);
		pulse(IX_RING, 2);
		aux_n = 0;
		pulse(IX_RING, 8);
		chk("ring mode rises", 24'h8, 24'(aux_n));
		$display("test divider done");
		// Passthrough then square-wave delay
		wr(ADDR_AUX1, 24'h5000a0);
		pulse(IX_VCO, 8);
		chk("delay pass", 24'h5, 24'(dly));
		wr(ADDR_AUX2, 24'h00000e);
		wr(ADDR_AUX1, 24'h280690);
		pulse(IX_VCO, 8);
		seen = 8'h00;
		pulse(IX_VCO, 64);
		chk("delay values seen", 24'h44, 24'(seen));
		// LFSR high amplitude shows at least three values in 16 steps
		wr(ADDR_AUX1, 24'h000da0);
		pulse(IX_VCO, 4);
		seen = 8'h00;
		pulse(IX_VCO, 64);
		chk("lfsr values", 24'h1, 24'($countones(seen) > 2));
		$display("test delay done");
		// Lock after exactly three in-window reference edges
		wr(ADDR_LOCK, 24'h001003);
		ext[IX_INWIN] = 1'b1;
		ext[IX_BUSY] = 1'b1;
		cyc(8);
		pulse(IX_REF, 2);
		cyc(4);
		chk("lock early", 24'h0, 24'(lock_detect));
		pulse(IX_REF, 1);
		cyc(4);
		chk("lock", 24'h1, 24'(lock_detect));
		rchk(ADDR_STATUS, 24'h000021);
		cyc(2);
		chk("read pin idle", 24'h1, 24'(read_pin_out));
		srd_act = 1'b1;
		cyc(2);
		chk("read pin data", 24'h0, 24'(read_pin_out));
		wr(ADDR_LOCK, 24'h003003);
		cyc(2);
		chk("read pin forced", 24'h1, 24'(read_pin_out));
		srd_act = 1'b0;
		wr(ADDR_LOCK, 24'h000003);
		cyc(2);
		chk("read pin off", 24'h0, 24'(read_pin_out));
		ext[IX_INWIN] = 1'b0;
		cyc(8);
		pulse(IX_REF, 1);
		cyc(4);
		chk("unlock", 24'h0, 24'(lock_detect));
		$display("test lock done");
		close_out;
	end
endmodule : testbench
